// ===== src/isa_pkg.sv
/*
  Package for the two-wire slave address and acknowledge block: mode codes, field
  layouts, reset values, timing and the carrier structs.
  Assumes a single 20 MHz system clock and no register bus.
*/
// What this block does
// R1: ninth clock pulse of every byte is the acknowledge slot, receiver pulls data low
// R2: the byte's transmitter releases the data line during the acknowledge slot
// R3: acknowledge sampled in the slot is stored in the acknowledge status bit
// R4: both hold enables set: acknowledge comes from software acknowledge data bit
// R5: both hold enables clear: hardware generates the acknowledge itself
// R6: no acknowledge to data bytes when buffer full or receive overflow is already set
// R7: on each byte from Start until a mismatch, ack time flag sets after eighth falling clock edge
// R8: ack time flag works only with either hold enable set
// R9: mode select picks four slave modes, 7-bit and 10-bit variants
// R10: start/stop modes also raise the irq flag on Start, Restart, Stop
// R11: first byte after Start compared with address; 7-bit write match loads buffer, interrupts
// R12: 7-bit or 10-bit high byte mismatch skips to the next Start or Stop silently, no flag or interrupt; the ack time flag still sets with a hold enable set
// R13: address mask register shapes which addresses match
// R14: 7-bit mode ignores the read/write bit in the comparison
// R15: 10-bit high byte compared with 11110, A9, A8, 0 from address bits 2:1
// R16: after acking 10-bit high byte, set update flag, stretch clock until rewrite
// R17: low byte compares all eight bits; irq and update flag set, stretch regardless
// R18: software write to address register clears the update flag
// R19: 10-bit read only after full write match then Restart with high byte read
// R20: buffer write during a bus sequence sets write collision, write discarded
// R21: writes to control two low five bits ignored until Start completes
// R22: software acknowledge: data bit zero pulls line low, one releases it
// R23: clock stretch ends and clock is released once address register is written
package isa_pkg;

  // mode select codes, 7-bit and 10-bit, with and without start/stop interrupts
  localparam logic [3:0] ISA_MODE_7   = 4'h6;
  localparam logic [3:0] ISA_MODE_10  = 4'h7;
  localparam logic [3:0] ISA_MODE_7S  = 4'he;
  localparam logic [3:0] ISA_MODE_10S = 4'hf;

  // 10-bit high byte pattern and field positions
  localparam logic [4:0] ISA_TEN_HDR  = 5'h1e;
  localparam int         ISA_A9_POS   = 2;
  localparam int         ISA_A8_POS   = 1;
  localparam int         ISA_CTL2_LOW = 5;

  // reset values
  localparam logic [7:0] ISA_ADDR_RST = 8'h00;
  localparam logic [7:0] ISA_MASK_RST = 8'hff;
  localparam logic [7:0] ISA_BYTE_RST = 8'h00;

  // bits in a byte and FIFO depth
  localparam int         ISA_BITS     = 8;
  localparam int         ISA_FIFO_DEP = 8;

  // start hold time before a Start counts as complete
  localparam int ISA_CLK_HZ       = 20_000_000;
  localparam int ISA_START_HOLD_NS = 600;
  localparam int ISA_START_CYC =
    (ISA_START_HOLD_NS * (ISA_CLK_HZ / 1_000_000) + 999) / 1000;

  // status carried out of the block
  typedef struct packed {
    logic ack_status_bit;
    logic ack_time_flag;
    logic address_update_flag;
    logic write_collision_flag;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic serial_port_irq_flag;
    logic start_seen;
    logic stop_seen;
    logic read_req;
  } isa_status_t;

  // software control bits
  typedef struct packed {
    logic       address_hold_enable;
    logic       data_hold_enable;
    logic       ack_data_bit;
    logic [3:0] port_mode_select;
  } isa_ctrl_t;

endpackage

// ===== src/isa_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // --------------------------------------------------------------
  // flags
  // --------------------------------------------------------------
  assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  // storage is written only on accepted pushes
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== src/isa_slave.sv
/*
  Two-wire slave address match and acknowledge logic with clock stretching,
  write collision guard and a received-byte FIFO toward software.
  Assumes the bus clock and data come from another domain and are synchronised here;
  software writes arrive as one-cycle strobes on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_slave
  import isa_pkg::*;
#(
  parameter int FIFO_W = ISA_BITS,
  parameter int FIFO_D = ISA_FIFO_DEP
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire isa_ctrl_t   ctrl,
  input  wire logic        addr_wr,
  input  wire logic [7:0]  addr_wdata,
  input  wire logic        mask_wr,
  input  wire logic [7:0]  mask_wdata,
  input  wire logic        buf_wr,
  input  wire logic [7:0]  buf_wdata,
  input  wire logic        ctl2_wr,
  input  wire logic [7:0]  ctl2_wdata,
  input  wire logic        irq_clr,
  input  wire logic        write_collision_flag_clr,
  input  wire logic        ov_clr,
  output logic      [7:0]  ctl2_low,
  output logic      [7:0]  tx_byte,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [7:0]  rx_data,
  output isa_status_t      status
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    ISA_IDLE = 5'b00001,
    ISA_ADR  = 5'b00010,
    ISA_LOW  = 5'b00100,
    ISA_DATA = 5'b01000,
    ISA_SKIP = 5'b10000
  } isa_state_t;

  isa_state_t state_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [7:0] addr_r;
  logic [7:0] mask_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic       rw_r;
  logic       ten_ok_r;
  logic       ack_slot_r;
  logic       ack_drive_r;
  logic       stretch_r;
  logic       write_collision_flag_r;
  logic       ov_r;
  logic       bf_r;
  logic       irq_r;
  logic       ack_status_bit_r;
  logic       ack_time_flag_r;
  logic       ua_r;
  logic       low_r;
  logic       push_r;
  logic [7:0] push_d_r;
  logic [7:0] txb_r;
  logic [7:0] ctl2_r;
  logic [$clog2(ISA_START_CYC+1):0] st_cnt_r;
  logic       fifo_in_ready;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic ten_mode;
  logic ss_mode;
  logic hold_any;
  logic sw_ack;
  logic busy;
  logic byte_done;

  // match under mask; the mask bit at one means the address bit must agree
  function automatic logic adr_hit(input logic [7:0] rx, input logic [7:0] ad,
                                   input logic [7:0] mk, input logic [7:0] care);
    adr_hit = (((rx ^ ad) & mk & care) == 8'h00);
  endfunction

  // --------------------------------------------------------------
  // bus input synchronisers and edge detection
  // --------------------------------------------------------------
  // two stages first; edges are found on the second stage only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl_rise  = scl_s_r[1] && !scl_d_r;
  assign scl_fall  = !scl_s_r[1] && scl_d_r;
  assign start_c   = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
  assign stop_c    = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
  assign ten_mode  = (ctrl.port_mode_select == ISA_MODE_10) ||
                     (ctrl.port_mode_select == ISA_MODE_10S);             // R9
  assign ss_mode   = (ctrl.port_mode_select == ISA_MODE_7S) ||
                     (ctrl.port_mode_select == ISA_MODE_10S);             // R9
  assign hold_any  = ctrl.address_hold_enable || ctrl.data_hold_enable;
  assign sw_ack    = ctrl.address_hold_enable && ctrl.data_hold_enable;
  assign busy      = (state_r != ISA_IDLE) || (st_cnt_r != '0);
  assign byte_done = scl_fall && (bit_r == 4'(ISA_BITS - 1));

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  // address and mask; an address write also ends any stretch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= ISA_ADDR_RST;
      mask_r <= ISA_MASK_RST;
    end else begin
      if (addr_wr) begin
        addr_r <= addr_wdata;
      end
      if (mask_wr) begin
        mask_r <= mask_wdata;
      end
    end
  end

  // Start completes after a short hold; writes to control two low bits are dropped until then
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_cnt_r <= '0;
      ctl2_r   <= ISA_BYTE_RST;
    end else begin
      if (start_c) begin
        st_cnt_r <= ($bits(st_cnt_r))'(ISA_START_CYC);
      end else if (st_cnt_r != '0) begin
        st_cnt_r <= st_cnt_r - 1'b1;
      end
      if (ctl2_wr) begin
        ctl2_r[7:ISA_CTL2_LOW] <= ctl2_wdata[7:ISA_CTL2_LOW];
        if (st_cnt_r == '0 && !start_c) begin
          ctl2_r[ISA_CTL2_LOW-1:0] <= ctl2_wdata[ISA_CTL2_LOW-1:0];  // R21
        end
      end
    end
  end

  // outgoing buffer: a write while the bus is busy is dropped and flagged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txb_r  <= ISA_BYTE_RST;
      write_collision_flag_r <= 1'b0;
    end else begin
      if (buf_wr && !busy) begin
        txb_r <= buf_wdata;
      end
      // set beats clear in the same cycle
      if (buf_wr && busy) begin
        write_collision_flag_r <= 1'b1;                                                   // R20
      end else if (write_collision_flag_clr) begin
        write_collision_flag_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // byte engine
  // --------------------------------------------------------------
  // bit counter runs 0..7; ack_slot_r marks the ninth, acknowledge pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ISA_IDLE;
      shift_r     <= ISA_BYTE_RST;
      bit_r       <= '0;
      rw_r        <= 1'b0;
      ten_ok_r    <= 1'b0;
      ack_slot_r  <= 1'b0;
      ack_drive_r <= 1'b0;
      push_r      <= 1'b0;
      push_d_r    <= ISA_BYTE_RST;
    end else begin
      push_r <= 1'b0;
      if (start_c) begin
        state_r    <= ISA_ADR;
        bit_r      <= '1;  // the clock fall that ends the Start wraps this to zero
        ack_slot_r <= 1'b0;
        ack_drive_r <= 1'b0;
      end else if (stop_c) begin
        state_r     <= ISA_IDLE;
        ten_ok_r    <= 1'b0;
        ack_slot_r  <= 1'b0;
        ack_drive_r <= 1'b0;
      end else begin
        case (state_r)
          ISA_IDLE: begin
            bit_r <= '0;
          end
          ISA_ADR, ISA_LOW, ISA_DATA: begin
            if (scl_rise && !ack_slot_r) begin
              shift_r <= {shift_r[6:0], sda_s_r[1]};
            end
            if (scl_fall && ack_slot_r) begin
              // end of the ninth pulse: release the line, next byte
              ack_slot_r  <= 1'b0;
              ack_drive_r <= 1'b0;                                        // R1
              bit_r       <= '0;
            end else if (byte_done) begin
              bit_r      <= '0;
              ack_slot_r <= 1'b1;                                         // R1
              if (state_r == ISA_ADR && !ten_mode) begin
                rw_r <= shift_r[0];
                if (adr_hit(shift_r, addr_r, mask_r, 8'hfe)) begin        // R14 R13
                  ack_drive_r <= sw_ack ? !ctrl.ack_data_bit : 1'b1;      // R4 R5 R22
                  push_r      <= !shift_r[0];                             // R11
                  push_d_r    <= shift_r;
                  state_r     <= ISA_DATA;
                end else begin
                  state_r <= ISA_SKIP;                                    // R12
                end
              end else if (state_r == ISA_ADR) begin
                rw_r <= shift_r[0];
                if (shift_r[7:3] == ISA_TEN_HDR &&
                    shift_r[2:1] == {addr_r[ISA_A9_POS], addr_r[ISA_A8_POS]} &&
                    (!shift_r[0] || ten_ok_r)) begin                      // R15 R19
                  ack_drive_r <= sw_ack ? !ctrl.ack_data_bit : 1'b1;      // R4 R5
                  state_r     <= shift_r[0] ? ISA_DATA : ISA_LOW;         // R19
                end else begin
                  state_r <= ISA_SKIP;                                    // R12
                end
              end else if (state_r == ISA_LOW) begin
                // all eight bits compared; the result decides the next state
                if (adr_hit(shift_r, addr_r, mask_r, 8'hff)) begin        // R17 R13
                  ack_drive_r <= sw_ack ? !ctrl.ack_data_bit : 1'b1;
                  ten_ok_r    <= 1'b1;
                  push_r      <= 1'b1;                                    // R11
                  push_d_r    <= shift_r;
                  state_r     <= ISA_DATA;
                end else begin
                  state_r <= ISA_SKIP;
                end
              end else if (!rw_r) begin
                // received data: no ack when full or overflowed
                ack_drive_r <= (bf_r || ov_r) ? 1'b0 :
                               (sw_ack ? !ctrl.ack_data_bit : 1'b1);       // R6 R4 R5
                push_r      <= !(bf_r || ov_r);
                push_d_r    <= shift_r;
              end
            end else if (scl_fall) begin
              bit_r <= bit_r + 1'b1;
            end
          end
          ISA_SKIP: begin
            bit_r <= '0;
          end
          default: begin
            state_r <= ISA_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------
  // acknowledge status: sampled on the ninth rising edge while reading out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_status_bit_r <= 1'b0;
      ack_time_flag_r  <= 1'b0;
    end else begin
      if (ack_slot_r && scl_rise && state_r == ISA_DATA && rw_r) begin
        ack_status_bit_r <= sda_s_r[1];                                          // R3 R2
      end
      if (byte_done && state_r != ISA_SKIP && state_r != ISA_IDLE && hold_any) begin
        ack_time_flag_r <= 1'b1;                                                 // R7 R8
      end else if (ack_slot_r && scl_fall || !hold_any) begin
        ack_time_flag_r <= 1'b0;                                                 // R8
      end
    end
  end

  // update flag and stretch; an address write ends both, a new event wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ua_r      <= 1'b0;
      stretch_r <= 1'b0;
      low_r     <= 1'b0;
    end else begin
      // both halves set it after their ninth pulse, which is never held itself
      if (ack_slot_r && scl_fall && ten_mode && (state_r == ISA_LOW || low_r)) begin
        ua_r      <= 1'b1;                                                // R16 R17
        stretch_r <= 1'b1;                                                // R16 R17
      end else if (addr_wr) begin
        ua_r      <= 1'b0;                                                // R18
        stretch_r <= 1'b0;                                                // R23
      end
      // marks that the running slot follows the low address half, matched or not
      if (byte_done && state_r == ISA_LOW) begin
        low_r <= 1'b1;
      end else if (scl_fall) begin
        low_r <= 1'b0;
      end
    end
  end

  // interrupt and overflow flags; set beats clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
      ov_r  <= 1'b0;
    end else begin
      if (push_r || (byte_done && state_r == ISA_LOW) ||
          (ss_mode && (start_c || stop_c))) begin
        irq_r <= 1'b1;                                                    // R10 R11 R17
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
      if (byte_done && state_r == ISA_DATA && !rw_r && bf_r) begin
        ov_r <= 1'b1;                                                     // R6
      end else if (ov_clr) begin
        ov_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // received bytes toward software
  // --------------------------------------------------------------
  // full flag mirrors back-pressure: software not draining stops data byte acks
  assign bf_r = !fifo_in_ready;

  isa_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .in_data   (push_d_r),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // --------------------------------------------------------------
  // pins and outputs
  // --------------------------------------------------------------
  // open drain: both pins only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe   = ack_slot_r && ack_drive_r;                            // R1 R22
  assign scl_o    = 1'b0;
  assign scl_oe   = stretch_r && !scl_s_r[1];                             // R16 R23
  assign ctl2_low = ctl2_r;
  assign tx_byte  = txb_r;

  assign status.ack_status_bit        = ack_status_bit_r;
  assign status.ack_time_flag         = ack_time_flag_r;
  assign status.address_update_flag   = ua_r;
  assign status.write_collision_flag  = write_collision_flag_r;
  assign status.buffer_full_flag      = bf_r;
  assign status.receive_overflow_flag = ov_r;
  assign status.serial_port_irq_flag  = irq_r;
  assign status.start_seen            = st_cnt_r != '0;
  assign status.stop_seen             = state_r == ISA_IDLE;
  assign status.read_req              = rw_r && state_r == ISA_DATA;

endmodule
`default_nettype wire

// ===== dv/isa_slave_asserts.sv
/*
  Checker for the two-wire slave: port-level relations on ref_clk.
  Assumes one clock domain; bound into isa_slave below.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_slave_asserts
  import isa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire isa_ctrl_t   ctrl,
  input wire logic        addr_wr,
  input wire logic        buf_wr,
  input wire logic [7:0]  tx_byte,
  input wire isa_status_t status
);
  // ---------------------------------------------
  // port relations
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // open drain: the pins may only ever be pulled low
  AST_OD_LOW: assert property (!sda_o && !scl_o) else $error("pin driven high");
  AST_ATIM_GATE: assert property (!(ctrl.address_hold_enable || ctrl.data_hold_enable)
    |-> !status.ack_time_flag) else $error("ack time flag without hold enable");
  AST_UA_CLR: assert property (addr_wr |=> !status.address_update_flag)
    else $error("update flag survived address write");
  AST_STRETCH_UA: assert property (scl_oe |-> status.address_update_flag)
    else $error("clock held without update flag");
  AST_STRETCH_REL: assert property (addr_wr |=> ##[0:2] !scl_oe)
    else $error("clock not released after address write");
  AST_SW_ACK: assert property (ctrl.address_hold_enable && ctrl.data_hold_enable
    && ctrl.ack_data_bit && !status.read_req |-> !sda_oe)
    else $error("data pulled low with software nack");
  AST_WRITE_COLLISION_FLAG: assert property ($rose(status.write_collision_flag) |-> $past(buf_wr))
    else $error("collision flag without buffer write");
  AST_TXHOLD: assert property ($rose(status.write_collision_flag) |-> $stable(tx_byte))
    else $error("buffer changed by refused write");
endmodule
bind isa_slave isa_slave_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .ctrl(ctrl), .addr_wr(addr_wr),
  .buf_wr(buf_wr), .tx_byte(tx_byte), .status(status));
`default_nettype wire

// ===== dv/isa_bus_master.sv
/*
  Behavioural bus master at the far side of the slave: start, stop, byte.
  Assumes pulled-up wires; 1 on an output means released. 400 ns bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_bus_master (
  input wire logic scl,
  input wire logic sda,
  output var logic scl_m,
  output var logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // ---------------------------------------------
  // frame tasks; the clock stands still between frames
  // ---------------------------------------------
  task automatic start();
    sda_m = 1'b1;
    #100 scl_m = 1'b1;
    #200 sda_m = 1'b0;
    #200 scl_m = 1'b0;
    #100;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #100 scl_m = 1'b1;
    #200 sda_m = 1'b1;
    #200;
  endtask
  // a stretched clock is honoured by waiting for the wire to rise
  task automatic bit_slot(input logic b, output logic s);
    sda_m = b;
    #100 scl_m = 1'b1;
    wait (scl);
    s = sda;
    #200 scl_m = 1'b0;
    #100;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, ack);
  endtask
endmodule
`default_nettype wire

// ===== dv/test_isa_slave.sv
/*
  Testbench for isa_slave: address match, acknowledge, FIFO fill, 10-bit stretch.
  Assumes isa_bus_master as the far side and the isa_pkg constants.
*/
`timescale 1ns/1ps
`default_nettype none
module test_isa_slave;
  import isa_pkg::*;
  logic ref_clk = 0, rst_n = 0, scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe, a, rx_valid;
  logic addr_wr = 0, mask_wr = 0, buf_wr = 0, ctl2_wr = 0, irq_clr = 0, write_collision_flag_clr = 0;
  logic rx_ready = 0, atim = 0;
  logic [7:0] wd = 0, ctl2_low, tx_byte, rx_data, t;
  isa_ctrl_t ctrl = '{1'b0, 1'b0, 1'b0, ISA_MODE_7};
  isa_status_t status;
  int n_errors = 0, n_compared = 0;
  wire scl = scl_m & ~scl_oe;
  wire sda = sda_m & ~sda_oe;
  isa_bus_master m (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  isa_slave dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .ctrl(ctrl),
    .addr_wr(addr_wr), .addr_wdata(wd), .mask_wr(mask_wr), .mask_wdata(wd),
    .buf_wr(buf_wr), .buf_wdata(wd), .ctl2_wr(ctl2_wr), .ctl2_wdata(wd),
    .irq_clr(irq_clr), .write_collision_flag_clr(write_collision_flag_clr), .ov_clr(1'b0), .ctl2_low(ctl2_low),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .status(status));
  initial forever #25 ref_clk = ~ref_clk;
  // remember any ack time flag seen since the bench last cleared it
  always @(posedge ref_clk) atim <= rst_n & (atim | status.ack_time_flag);
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // k: 0 address, 1 mask, 2 buffer, 3 control two, 4 irq clear, 5 collision clear
  task automatic wr(input int k, input logic [7:0] v);
    @(negedge ref_clk);
    wd = v;
    {addr_wr, mask_wr, buf_wr, ctl2_wr, irq_clr, write_collision_flag_clr} = 6'h20 >> k;
    @(negedge ref_clk);
    {addr_wr, mask_wr, buf_wr, ctl2_wr, irq_clr, write_collision_flag_clr} = 6'h00;
  endtask
  task automatic frame(input logic [7:0] b, input logic e);
    m.start();
    m.send(b, a);
    chk("ack", e, a);
    m.stop();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400_000;
    n_errors++;
    report_and_stop();
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1;
    chk("status", 10'h002, status); // idle reads as stop seen
    wr(0, 8'h50);
    frame(8'h52, 1'b1);
    chk("irq", 1'b0, status.serial_port_irq_flag);
    chk("rx_valid", 1'b0, rx_valid);
    wr(1, 8'hfd);
    frame(8'h52, 1'b0);
    chk("irq", 1'b1, status.serial_port_irq_flag);
    chk("atim", 1'b0, atim);
    chk("rx_data", 8'h52, rx_data);
    rx_ready = 1;
    @(negedge ref_clk);
    rx_ready = 0;
    wr(1, 8'hff);
    // fill the FIFO until the slave refuses, then drain it
    m.start();
    for (int i = 0; i < 9; i++) begin
      m.send((i == 0) ? 8'h50 : 8'(i), a);
      chk("ack", (i == 8), a);
    end
    m.stop();
    chk("ov", 1'b1, status.receive_overflow_flag);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      chk("rx_data", {1'b1, (i == 0) ? 8'h50 : 8'(i)}, {rx_valid, rx_data});
      rx_ready = 1;
      @(negedge ref_clk);
      rx_ready = 0;
    end
    chk("rx_valid", 1'b0, rx_valid);
    rx_ready = 1;
    // software acknowledge with both hold enables
    for (int j = 0; j < 2; j++) begin
      @(negedge ref_clk);
      ctrl = '{1'b1, 1'b1, 1'(j), ISA_MODE_7};
      atim = 0;
      frame(8'h50, 1'(j));
      chk("atim", 1'b1, atim);
    end
    @(negedge ref_clk);
    ctrl = '{1'b0, 1'b0, 1'b0, ISA_MODE_7S};
    wr(4, 8'h00);
    // control two writes refused while the Start completes
    fork
      m.start();
      begin
        #400;
        wr(3, 8'h15);
      end
    join
    chk("ctl2_low", 5'h00, ctl2_low[4:0]);
    chk("irq", 1'b1, status.serial_port_irq_flag);
    t = tx_byte;
    fork
      m.send(8'h50, a);
      begin
        #1000;
        wr(2, 8'ha5);
      end
    join
    m.stop();
    repeat (4) @(negedge ref_clk);
    chk("write_collision_flag", 1'b1, status.write_collision_flag);
    chk("tx_byte", t, tx_byte);
    wr(2, 8'h3c);
    wr(3, 8'h15);
    chk("tx_byte", 8'h3c, tx_byte);
    chk("ctl2_low", 5'h15, ctl2_low[4:0]);
    wr(5, 8'h00);
    // 10-bit address with clock stretching between halves
    ctrl.port_mode_select = ISA_MODE_10;
    wr(4, 8'h00);
    wr(0, 8'h06);
    m.start();
    m.send(8'hf6, a);
    chk("ack", 1'b0, a);
    repeat (4) @(negedge ref_clk);
    chk("ua_stretch", 2'b11, {status.address_update_flag, scl_oe});
    wr(0, 8'h34);
    chk("ua_stretch", 2'b00, {status.address_update_flag, scl_oe});
    m.send(8'h34, a);
    chk("ack", 1'b0, a);
    repeat (4) @(negedge ref_clk);
    chk("ua_irq", 2'b11, {status.address_update_flag, status.serial_port_irq_flag});
    wr(0, 8'h06);
    // Restart with the high half as a read after the full match
    m.start();
    m.send(8'hf7, a);
    chk("ack", 1'b0, a);
    m.stop();
    report_and_stop();
  end
endmodule
`default_nettype wire
